/* ifm_pkg.sv */
package ifm_pkg;
   localparam int IFM_ADDR_W = 4;
   localparam logic [3:0] IFM_OFS_STATUS = 4'h0;
   localparam logic [3:0] IFM_OFS_MASK = 4'h4;
   localparam logic [3:0] IFM_OFS_FLAGS = 4'h8;
   localparam logic [3:0] IFM_OFS_COUNT = 4'hC;
   localparam int IFM_BIT_OVF = 0;
   localparam int IFM_BIT_AOVF = 1;
   localparam logic [1:0] IFM_STATUS_RST = 2'h0;
   localparam logic [1:0] IFM_MASK_RST = 2'h0;
   localparam logic [15:0] IFM_COUNT_RST = 16'h0000;
   localparam logic [15:0] IFM_HALF_MIN = 16'h8000;
   // packed forms saturate to this value
   localparam logic [31:0] IFM_SAT_PACKED = 32'h07FF_FFFF;
   // single 16x16 fraction form saturates to this value
   localparam logic [31:0] IFM_SAT_Q16 = 32'h7FFF_FFFF;
   localparam logic [31:0] IFM_SMAX32 = 32'h7FFF_FFFF;
   localparam logic [31:0] IFM_SMIN32 = 32'h8000_0000;
   localparam logic [31:0] IFM_UMAX32 = 32'hFFFF_FFFF;

   typedef enum logic [3:0] {
      IFM_OP_MUL32 = 4'h0,
      IFM_OP_MULS = 4'h1,
      IFM_OP_MULH = 4'h2,
      IFM_OP_MULM = 4'h3,
      IFM_OP_Q16 = 4'h4,
      IFM_OP_Q1632 = 4'h5,
      IFM_OP_Q3232 = 4'h6,
      IFM_OP_Q16_64 = 4'h7,
      IFM_OP_Q32_64 = 4'h8,
      IFM_OP_MULU = 4'h9,
      IFM_OP_MULSU = 4'hA
   } ifm_op_type;

   typedef enum logic [1:0] {
      upper_upper_lower_lower_pairing = 2'h0,
      upper_lower_lower_upper_pairing = 2'h1,
      upper_lower_lower_lower_pairing = 2'h2,
      lower_upper_upper_upper_pairing = 2'h3
   } ifm_pair_type;

   typedef struct packed {
      ifm_op_type op;
      ifm_pair_type pair;
      logic hsel_upper;
      logic frac;
      logic use_imm;
      logic [8:0] nine_bit_immediate;
      logic [31:0] a;
      logic [31:0] b;
   } ifm_req_type;

   typedef struct packed {
      logic [31:0] hi;
      logic [31:0] lo;
      logic wide;
      logic ovf;
      logic advanced_overflow_flag;
   } ifm_res_type;
endpackage : ifm_pkg

/* ifm_multiplier.sv */
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module ifm_multiplier (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // operation request
   input wire logic i_req_valid,
   input wire ifm_pkg::ifm_req_type i_req,
   // result
   output logic o_res_valid,
   output ifm_pkg::ifm_res_type o_res,
   // register port
   input wire logic [ifm_pkg::IFM_ADDR_W-1:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   // status
   output logic o_irq,
   output logic o_sticky_overflow_flag,
   output logic o_sticky_advanced_overflow_flag
);
   import ifm_pkg::*;

   // signed 16x16 product with optional doubling and corner saturation
   function automatic logic [31:0] ifm_hmul(input logic [15:0] x, input logic [15:0] y,
                                            input logic n, input logic [31:0] sat);
      logic signed [31:0] p;
      p = $signed(x) * $signed(y);
      if (n && (x == IFM_HALF_MIN) && (y == IFM_HALF_MIN)) begin
         return sat;
      end
      return n ? {p[30:0], 1'b0} : p;
   endfunction : ifm_hmul

   // datapath signals
   logic [15:0] a_hi;
   logic [15:0] a_lo;
   logic [15:0] b_hi;
   logic [15:0] b_lo;
   logic [15:0] x1;
   logic [15:0] y1;
   logic [15:0] x2;
   logic [15:0] y2;
   logic [15:0] hsel;
   logic [31:0] ph1;
   logic [31:0] ph2;
   logic [63:0] msum;
   logic signed [47:0] p48;
   logic [47:0] p48s;
   logic signed [63:0] p64;
   logic [63:0] p64s;
   logic [31:0] bu;
   logic [63:0] u64;
   logic s32_fits;
   ifm_res_type res_calc;

   // result state
   logic res_valid_reg;
   logic res_valid_next;
   ifm_res_type res_reg;
   ifm_res_type res_next;

   // register file state
   logic [1:0] status_reg;
   logic [1:0] status_next;
   logic [1:0] mask_reg;
   logic [1:0] mask_next;
   logic [1:0] flags_reg;
   logic [1:0] flags_next;
   logic [15:0] count_reg;
   logic [15:0] count_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;

   // operand selection
   always_comb begin
      a_hi = i_req.a[31:16];
      a_lo = i_req.a[15:0];
      b_hi = i_req.b[31:16];
      b_lo = i_req.b[15:0];
      // defaults keep the selection free of latches when the pairing code is unknown
      x1 = a_hi;
      y1 = b_hi;
      x2 = a_lo;
      y2 = b_lo;
      unique case (i_req.pair)
         upper_upper_lower_lower_pairing: begin
            x1 = a_hi;
            y1 = b_hi;
            x2 = a_lo;
            y2 = b_lo;
         end
         upper_lower_lower_upper_pairing: begin
            x1 = a_hi;
            y1 = b_lo;
            x2 = a_lo;
            y2 = b_hi;
         end
         upper_lower_lower_lower_pairing: begin
            x1 = a_hi;
            y1 = b_lo;
            x2 = a_lo;
            y2 = b_lo;
         end
         lower_upper_upper_upper_pairing: begin
            x1 = a_lo;
            y1 = b_hi;
            x2 = a_hi;
            y2 = b_hi;
         end
      endcase
      hsel = i_req.hsel_upper ? b_hi : b_lo;
   end

   // product generation
   always_comb begin
      ph1 = ifm_hmul(x1, y1, i_req.frac, IFM_SAT_PACKED);
      ph2 = ifm_hmul(x2, y2, i_req.frac, IFM_SAT_PACKED);
      msum = {{32{ph1[31]}}, ph1} + {{32{ph2[31]}}, ph2};
      p48 = $signed(i_req.a) * $signed(hsel);
      p48s = i_req.frac ? {p48[46:0], 1'b0} : p48;
      p64 = $signed(i_req.a) * $signed(i_req.b);
      p64s = i_req.frac ? {p64[62:0], 1'b0} : p64;
      bu = i_req.use_imm ? {23'h00_0000, i_req.nine_bit_immediate} : i_req.b;
      u64 = {32'h0000_0000, i_req.a} * {32'h0000_0000, bu};
      s32_fits = (p64[63:31] == {33{1'b0}}) || (p64[63:31] == {33{1'b1}});
   end

   // result formation and flags
   always_comb begin
      res_calc = '0;
      unique case (i_req.op)
         IFM_OP_MUL32: begin
            // also serves the non-saturating unsigned 32-bit form
            res_calc.lo = p64[31:0];
            res_calc.ovf = ~s32_fits;
            res_calc.advanced_overflow_flag = res_calc.lo[31] ^ res_calc.lo[30];
         end
         IFM_OP_MULS: begin
            if (s32_fits) begin
               res_calc.lo = p64[31:0];
            end else begin
               res_calc.lo = p64[63] ? IFM_SMIN32 : IFM_SMAX32;
            end
            res_calc.ovf = ~s32_fits;
            res_calc.advanced_overflow_flag = res_calc.lo[31] ^ res_calc.lo[30];
         end
         IFM_OP_MULH: begin
            res_calc.wide = 1'b1;
            res_calc.hi = ph1;
            res_calc.lo = ph2;
            res_calc.advanced_overflow_flag = res_calc.hi[31] ^ res_calc.hi[30];
         end
         IFM_OP_MULM: begin
            res_calc.wide = 1'b1;
            {res_calc.hi, res_calc.lo} = {msum[47:0], 16'h0000};
            res_calc.ovf = 1'b0;
            res_calc.advanced_overflow_flag = 1'b0;
         end
         IFM_OP_Q16: begin
            if (i_req.hsel_upper) begin
               res_calc.lo = ifm_hmul(a_hi, b_hi, i_req.frac, IFM_SAT_Q16);
            end else begin
               res_calc.lo = ifm_hmul(a_lo, b_lo, i_req.frac, IFM_SAT_Q16);
            end
            res_calc.advanced_overflow_flag = res_calc.lo[31] ^ res_calc.lo[30];
         end
         IFM_OP_Q1632: begin
            res_calc.lo = p48s[47:16];
            res_calc.advanced_overflow_flag = res_calc.lo[31] ^ res_calc.lo[30];
         end
         IFM_OP_Q3232: begin
            res_calc.lo = p64s[63:32];
            res_calc.advanced_overflow_flag = res_calc.lo[31] ^ res_calc.lo[30];
         end
         IFM_OP_Q16_64: begin
            res_calc.wide = 1'b1;
            {res_calc.hi, res_calc.lo} = {{16{p48s[47]}}, p48s};
            res_calc.advanced_overflow_flag = res_calc.hi[31] ^ res_calc.hi[30];
         end
         IFM_OP_Q32_64: begin
            res_calc.wide = 1'b1;
            {res_calc.hi, res_calc.lo} = p64s;
            res_calc.advanced_overflow_flag = res_calc.hi[31] ^ res_calc.hi[30];
         end
         IFM_OP_MULU: begin
            res_calc.wide = 1'b1;
            {res_calc.hi, res_calc.lo} = u64;
            res_calc.ovf = 1'b0;
            res_calc.advanced_overflow_flag = res_calc.hi[31] ^ res_calc.hi[30];
         end
         IFM_OP_MULSU: begin
            res_calc.lo = (u64[63:32] != 32'h0000_0000) ? IFM_UMAX32 : u64[31:0];
            res_calc.ovf = (u64[63:32] != 32'h0000_0000);
            res_calc.advanced_overflow_flag = res_calc.lo[31] ^ res_calc.lo[30];
         end
         default: begin
            res_calc = '0;
         end
      endcase
   end

   // result pipeline next state
   always_comb begin
      res_valid_next = i_req_valid;
      res_next = res_reg;
      if (i_req_valid) begin
         res_next = res_calc;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         res_valid_reg <= 1'b0;
         res_reg <= '0;
      end else begin
         res_valid_reg <= res_valid_next;
         res_reg <= res_next;
      end
   end

   // register file next state; a set in the clearing cycle wins
   always_comb begin
      status_next = status_reg;
      mask_next = mask_reg;
      flags_next = flags_reg;
      count_next = count_reg;
      rdata_next = 32'h0000_0000;
      if (i_wr && (i_addr == IFM_OFS_STATUS)) begin
         status_next = status_reg & ~i_wdata[1:0];
      end
      if (i_wr && (i_addr == IFM_OFS_MASK)) begin
         mask_next = i_wdata[1:0];
      end
      if (res_valid_reg) begin
         flags_next[IFM_BIT_OVF] = res_reg.ovf;
         flags_next[IFM_BIT_AOVF] = res_reg.advanced_overflow_flag;
         status_next[IFM_BIT_OVF] = status_next[IFM_BIT_OVF] | res_reg.ovf;
         status_next[IFM_BIT_AOVF] = status_next[IFM_BIT_AOVF]
                                     | res_reg.advanced_overflow_flag;
         count_next = count_reg + 16'h0001;
      end
      if (i_rd) begin
         unique case (i_addr)
            IFM_OFS_STATUS: rdata_next = {30'h0000_0000, status_reg};
            IFM_OFS_MASK: rdata_next = {30'h0000_0000, mask_reg};
            IFM_OFS_FLAGS: rdata_next = {30'h0000_0000, flags_reg};
            IFM_OFS_COUNT: rdata_next = {16'h0000, count_reg};
            default: rdata_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         status_reg <= IFM_STATUS_RST;
         mask_reg <= IFM_MASK_RST;
         flags_reg <= IFM_STATUS_RST;
         count_reg <= IFM_COUNT_RST;
         rdata_reg <= 32'h0000_0000;
      end else begin
         status_reg <= status_next;
         mask_reg <= mask_next;
         flags_reg <= flags_next;
         count_reg <= count_next;
         rdata_reg <= rdata_next;
      end
   end

   assign o_res_valid = res_valid_reg;
   assign o_res = res_reg;
   assign o_rdata = rdata_reg;
   assign o_irq = |(status_reg & mask_reg);
   assign o_sticky_overflow_flag = status_reg[IFM_BIT_OVF];
   assign o_sticky_advanced_overflow_flag = status_reg[IFM_BIT_AOVF];
endmodule : ifm_multiplier

/* ifm_multiplier_monitor.sv */
`timescale 1ns/1ps
module ifm_multiplier_monitor (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // operation path
   input wire logic i_req_valid,
   input wire ifm_pkg::ifm_req_type i_req,
   input wire logic o_res_valid,
   input wire ifm_pkg::ifm_res_type o_res,
   // register port
   input wire logic [ifm_pkg::IFM_ADDR_W-1:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [31:0] o_rdata,
   // status
   input wire logic o_irq,
   input wire logic o_sticky_overflow_flag,
   input wire logic o_sticky_advanced_overflow_flag
);
   import ifm_pkg::*;
   logic [31:0] ub;
   logic [63:0] uprod;
   logic clr_o;
   logic clr_a;
   assign ub = i_req.use_imm ? {23'h0, i_req.nine_bit_immediate} : i_req.b;
   assign uprod = {32'h0000_0000, i_req.a} * {32'h0000_0000, ub};
   assign clr_o = i_wr && i_addr == IFM_OFS_STATUS && i_wdata[IFM_BIT_OVF];
   assign clr_a = i_wr && i_addr == IFM_OFS_STATUS && i_wdata[IFM_BIT_AOVF];
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_b);
   sequence s_op(ifm_op_type k);
      i_req_valid && i_req.op == k;
   endsequence
   sequence s_aov_event;
      o_res_valid && o_res.advanced_overflow_flag;
   endsequence
   AST_RES_NEXT: assert property (i_req_valid |=> o_res_valid)
      else $error("result missing");
   AST_RES_ONLY: assert property (!i_req_valid |=> !o_res_valid)
      else $error("result without request");
   AST_MULM_FLAGS: assert property (s_op(IFM_OP_MULM) |=> !o_res.ovf && !o_res.advanced_overflow_flag)
      else $error("multiprecision flags set");
   AST_MULM_SHIFT: assert property (s_op(IFM_OP_MULM) |=> o_res.wide && o_res.lo[15:0] == 16'h0000)
      else $error("multiprecision low bits");
   AST_MULH_OVF: assert property (s_op(IFM_OP_MULH) |=> o_res.wide && !o_res.ovf)
      else $error("packed overflow set");
   AST_Q16_HI: assert property (s_op(IFM_OP_Q16) |=> o_res.hi == 32'h0000_0000 && !o_res.wide)
      else $error("short result upper word");
   AST_Q16_64_SIGN: assert property (s_op(IFM_OP_Q16_64) |=> o_res.hi[31:16] == {16{o_res.hi[15]}})
      else $error("wide fraction sign fill");
   AST_MULSU_CLAMP: assert property (s_op(IFM_OP_MULSU) ##0 uprod[63:32] != 32'h0 |=> o_res.lo == IFM_UMAX32 && o_res.ovf)
      else $error("unsigned clamp");
   AST_MULU_PROD: assert property (s_op(IFM_OP_MULU) |=> {o_res.hi, o_res.lo} == $past(uprod))
      else $error("unsigned product");
   AST_SOV_SET: assert property (o_res_valid && o_res.ovf |=> o_sticky_overflow_flag)
      else $error("sticky overflow not set");
   AST_SOV_HOLD: assert property (o_sticky_overflow_flag && !clr_o |=> o_sticky_overflow_flag)
      else $error("sticky overflow lost");
   AST_SAOV_SET: assert property (s_aov_event |=> o_sticky_advanced_overflow_flag)
      else $error("sticky advanced not set");
   AST_SAOV_HOLD: assert property (o_sticky_advanced_overflow_flag && !clr_a |=> $stable(o_sticky_advanced_overflow_flag))
      else $error("sticky advanced lost");
endmodule : ifm_multiplier_monitor

/* ifm_core_model.sv */
`timescale 1ns/1ps
module ifm_core_model (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // decoded instruction
   input wire logic i_issue,
   input wire ifm_pkg::ifm_req_type i_word,
   // request to multiplier
   output logic o_req_valid,
   output ifm_pkg::ifm_req_type o_req
);
   import ifm_pkg::*;
   ifm_req_type req_next;
   // idle cycles show the previous request inverted, so a stale value returns every second idle cycle
   always_comb begin
      req_next = i_issue ? i_word : ~o_req;
   end
   always_ff @(posedge i_clk) begin
      o_req_valid <= i_rst_b & i_issue;
      o_req <= req_next;
   end
endmodule : ifm_core_model

/* ifm_multiplier_tb_top.sv */
`timescale 1ns/1ps
module ifm_multiplier_tb_top;
   import ifm_pkg::*;
   logic i_clk = 0, i_rst_b = 0, issue = 0, i_wr = 0, i_rd = 0, rv, resv, o_irq, sov, saov;
   logic [3:0] i_addr = 4'h0;
   logic [31:0] i_wdata = 32'h0, o_rdata, erd;
   logic [1:0] st, msk, flg;
   logic [15:0] cnt;
   ifm_req_type w = '0, rq, t;
   ifm_res_type o_res, e;
   ifm_res_type q[$];
   int n_errors = 0, samples_checked = 0, k;
   logic [31:0] kv[3] = '{32'h8000_8000, 32'h8000_0000, 32'hFFFF_FFFF};
   logic [3:0] ad[5] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'h2};
   ifm_core_model u_core (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_issue(issue), .i_word(w),
      .o_req_valid(rv), .o_req(rq));
   ifm_multiplier uut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_req_valid(rv), .i_req(rq),
      .o_res_valid(resv), .o_res(o_res), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .o_sticky_overflow_flag(sov),
      .o_sticky_advanced_overflow_flag(saov));
   function automatic logic [31:0] hp(logic [15:0] x, logic [15:0] y, logic n, logic [31:0] s);
      logic signed [31:0] p;
      p = $signed(x) * $signed(y);
      return (n && x == IFM_HALF_MIN && y == IFM_HALF_MIN) ? s : p << n;
   endfunction : hp
   function automatic ifm_res_type ref_f(ifm_req_type r);
      ifm_res_type o;
      logic [63:0] x, f;
      logic [31:0] b, p1, p2;
      logic [15:0] h;
      o = '0;
      b = r.use_imm ? {23'h0, r.nine_bit_immediate} : r.b;
      h = r.hsel_upper ? r.b[31:16] : r.b[15:0];
      case (r.pair)
         upper_upper_lower_lower_pairing: f = {r.a[31:16], r.b[31:16], r.a[15:0], r.b[15:0]};
         upper_lower_lower_upper_pairing: f = {r.a[31:16], r.b[15:0], r.a[15:0], r.b[31:16]};
         upper_lower_lower_lower_pairing: f = {r.a[31:16], r.b[15:0], r.a[15:0], r.b[15:0]};
         default: f = {r.a[15:0], r.b[31:16], r.a[31:16], r.b[31:16]};
      endcase
      p1 = hp(f[63:48], f[47:32], r.frac, IFM_SAT_PACKED);
      p2 = hp(f[31:16], f[15:0], r.frac, IFM_SAT_PACKED);
      x = ($signed(r.a) * $signed(r.b)) << r.frac;
      case (r.op)
         IFM_OP_MUL32, IFM_OP_MULS: begin
            x = $signed(r.a) * $signed(r.b);
            o.lo = x[31:0];
            o.ovf = x != {{32{x[31]}}, x[31:0]};
            if (o.ovf && r.op == IFM_OP_MULS) o.lo = x[63] ? IFM_SMIN32 : IFM_SMAX32;
         end
         IFM_OP_MULH: {o.hi, o.lo} = {p1, p2};
         IFM_OP_MULM: {o.hi, o.lo} = ({{32{p1[31]}}, p1} + {{32{p2[31]}}, p2}) << 16;
         IFM_OP_Q16: o.lo = r.hsel_upper ? hp(r.a[31:16], r.b[31:16], r.frac, IFM_SAT_Q16) :
            hp(r.a[15:0], r.b[15:0], r.frac, IFM_SAT_Q16);
         IFM_OP_Q1632, IFM_OP_Q16_64: begin
            x = ($signed(r.a) * $signed(h)) << r.frac;
            o.lo = x[47:16];
            if (r.op == IFM_OP_Q16_64) {o.hi, o.lo} = {{16{x[47]}}, x[47:0]};
         end
         IFM_OP_Q3232: o.lo = x[63:32];
         IFM_OP_Q32_64: {o.hi, o.lo} = x;
         IFM_OP_MULU, IFM_OP_MULSU: begin
            x = {32'h0000_0000, r.a} * {32'h0000_0000, b};
            o.ovf = r.op == IFM_OP_MULSU && x[63:32] != 32'h0;
            {o.hi, o.lo} = r.op == IFM_OP_MULU ? x : {32'h0, o.ovf ? IFM_UMAX32 : x[31:0]};
         end
         default: ;
      endcase
      o.wide = r.op inside {IFM_OP_MULH, IFM_OP_MULM, IFM_OP_Q16_64, IFM_OP_Q32_64, IFM_OP_MULU};
      if (r.op != IFM_OP_MULM && r.op <= IFM_OP_MULSU)
         o.advanced_overflow_flag = o.wide ? o.hi[31] ^ o.hi[30] : o.lo[31] ^ o.lo[30];
      return o;
   endfunction : ref_f
   task automatic finish_test();
      $display("checked %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : finish_test
   task automatic chk_res(ifm_res_type g, ifm_res_type x);
      samples_checked++;
      if (g !== x) begin
         n_errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask : chk_res
   task automatic chk_val(logic [31:0] g, logic [31:0] x);
      samples_checked++;
      if (g !== x) begin
         n_errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask : chk_val
   always @(posedge i_clk) begin
      if (!i_rst_b) begin
         {st, msk, flg, cnt, erd} = '0;
         q.delete();
      end else begin
         chk_val(o_rdata, erd);
         chk_val({29'h0, saov, sov, o_irq}, {29'h0, st, |(st & msk)});
         erd = 32'h0;
         if (i_rd) begin
            case (i_addr)
               IFM_OFS_STATUS: erd = {30'h0, st};
               IFM_OFS_MASK: erd = {30'h0, msk};
               IFM_OFS_FLAGS: erd = {30'h0, flg};
               IFM_OFS_COUNT: erd = {16'h0, cnt};
               default: ;
            endcase
         end
         if (i_wr && i_addr == IFM_OFS_MASK) msk = i_wdata[1:0];
         if (i_wr && i_addr == IFM_OFS_STATUS) st = st & ~i_wdata[1:0];
         if (resv === 1'b1) begin
            e = q.size() > 0 ? q.pop_front() : 'x;
            chk_res(o_res, e);
            flg = {e.advanced_overflow_flag, e.ovf};
            st = st | flg;
            cnt++;
         end
         if (rv === 1'b1) q.push_back(ref_f(rq));
      end
   end
   initial begin
      forever #5 i_clk = ~i_clk;
   end
   initial begin
      repeat (20000) @(posedge i_clk);
      n_errors++;
      finish_test();
   end
   initial begin
      void'($urandom(15379));
      repeat (5) @(posedge i_clk);
      i_rst_b <= 1'b1;
      for (int i = 0; i < 800; i++) begin
         @(posedge i_clk);
         t.op = ifm_op_type'(i[3:0]);
         t.pair = ifm_pair_type'(i[5:4]);
         {t.hsel_upper, t.frac, t.use_imm} = 3'($urandom);
         t.nine_bit_immediate = 9'($urandom);
         t.a = i[6] ? kv[i % 3] : $urandom;
         t.b = i[6] ? kv[(i / 2) % 3] : $urandom;
         w <= t;
         issue <= $urandom_range(0, 4) != 0;
         k = $urandom_range(0, 2);
         i_rd <= k == 1;
         i_wr <= k == 2;
         i_addr <= ad[$urandom_range(0, 4)];
         i_wdata <= $urandom;
      end
      @(posedge i_clk);
      issue <= 1'b0;
      i_rd <= 1'b0;
      i_wr <= 1'b0;
      repeat (4) @(posedge i_clk);
      chk_val(32'(q.size()), 32'h0);
      finish_test();
   end
endmodule : ifm_multiplier_tb_top
bind ifm_multiplier ifm_multiplier_monitor u_mon (.i_clk(i_clk), .i_rst_b(i_rst_b),
   .i_req_valid(i_req_valid), .i_req(i_req), .o_res_valid(o_res_valid), .o_res(o_res),
   .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
   .o_irq(o_irq), .o_sticky_overflow_flag(o_sticky_overflow_flag),
   .o_sticky_advanced_overflow_flag(o_sticky_advanced_overflow_flag));
